// [rtl/dmbs_regs.svh]
// Register map, field positions, reset values and timing counts of the sequencer
`ifndef DMBS_REGS_SVH
`define DMBS_REGS_SVH
// ****************************************
// Register offsets
// ****************************************
`define DMBS_ADDR_CTRL      8'h00
`define DMBS_ADDR_SRC_TAB   8'h04
`define DMBS_ADDR_REL_DLY   8'h08
`define DMBS_ADDR_HOLD      8'h0c
`define DMBS_ADDR_FSTOP     8'h10
`define DMBS_ADDR_STATUS    8'h14
// ****************************************
// Field positions
// ****************************************
`define DMBS_CTRL_BRK_EN    0
`define DMBS_CTRL_DOUT_BRK  1
`define DMBS_CTRL_CHG_LSB   2
`define DMBS_CTRL_DI3_LSB   8
`define DMBS_TAB_E0_LSB     0
`define DMBS_TAB_E1_LSB     8
`define DMBS_FS_A_LSB       0
`define DMBS_FS_B_LSB       8
// ****************************************
// Reset values and codes
// ****************************************
`define DMBS_CTRL_RST       16'h0000
`define DMBS_TAB_RST        7'h00
`define DMBS_REL_DLY_RST    16'h01f4
`define DMBS_HOLD_RST       16'h012c
`define DMBS_FS_RST         3'h7
`define DMBS_DI3_CHG_FUNC   8'h63
// ****************************************
// Timing
// ****************************************
`define DMBS_CLK_PERIOD_NS  40
`define DMBS_MS_NS          1000000
`endif

// [rtl/dmbs_pkg.sv]
// Types shared by the sequencer modules
package dmbs_pkg;
    // Brake sequence states, Gray along start to stop
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_PREP    = 3'h1,
        ST_RELEASE = 3'h3,
        ST_RUN     = 3'h2,
        ST_RAMP    = 3'h6,
        ST_HOLD    = 3'h7
    } dmbs_state_t;

    // Changeover candidates
    typedef struct packed {
        logic di3;
        logic panel_cw15;
        logic comm_cw15;
        logic board_cw15;
    } dmbs_chg_in_t;

    // Decoded table entry
    typedef struct packed {
        logic       valid;
        logic [2:0] cmd_src;
        logic [2:0] sp_src;
    } dmbs_src_t;
endpackage

// [rtl/dmbs_src_decode.sv]
// Decoder of a source table entry code into command and setpoint source
`timescale 1ns/10ps
module dmbs_src_decode (
    // Code
    input  wire logic [6:0]        code_i,
    // Decoded pair
    output dmbs_pkg::dmbs_src_t    src_o
);
    // ****************************************
    // Tens digit, 7 for codes 20 to 39 and from 70 up
    // ****************************************
    function automatic logic [2:0] tens_of(input logic [6:0] c);
        if (c >= 7'h46) begin
            tens_of = 3'h7;
        end else if (c >= 7'h3c) begin
            tens_of = 3'h6;
        end else if (c >= 7'h32) begin
            tens_of = 3'h5;
        end else if (c >= 7'h28) begin
            tens_of = 3'h4;
        end else if (c >= 7'h14) begin
            tens_of = 3'h7;
        end else if (c >= 7'h0a) begin
            tens_of = 3'h1;
        end else begin
            tens_of = 3'h0;
        end
    endfunction

    logic [2:0] tens;
    logic [6:0] units;

    always_comb begin
        tens  = tens_of(code_i);
        units = code_i - ({4'h0, tens} * 7'h0a);
        src_o.cmd_src = tens;
        src_o.sp_src  = units[2:0];
        src_o.valid   = (tens != 3'h7) && (units <= 7'h06)
                        && (code_i != 7'h0e) && (code_i != 7'h38)
                        && (code_i != 7'h41);
    end
endmodule // dmbs_src_decode

// [rtl/dmbs_top.sv]
// Manual/automatic source selection and holding brake sequencer with AHB-Lite registers
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "dmbs_regs.svh"
module dmbs_top #(
    parameter int MS_TICK_CYC = `DMBS_MS_NS / `DMBS_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    srst_i,
    // AHB-Lite slave
    input  wire logic                    hsel_i,
    input  wire logic [7:0]              haddr_i,
    input  wire logic [1:0]              htrans_i,
    input  wire logic                    hwrite_i,
    input  wire logic [2:0]              hsize_i,
    input  wire logic [31:0]             hwdata_i,
    input  wire logic                    hready_i,
    output logic                         hreadyout_o,
    output logic                         hresp_o,
    output logic [31:0]                  hrdata_o,
    // Commands, on and fast stop requests one bit per command source, coast stop and changeover inputs single
    input  wire logic [4:0]              on_req_i,
    input  wire logic [4:0]              fast_stop_req_i,
    input  wire logic                    coast_stop_i,
    input  wire dmbs_pkg::dmbs_chg_in_t  chg_in_i,
    // Ramp generator feedback
    input  wire logic                    at_min_freq_i,
    input  wire logic                    stop_thr_done_i,
    // Drive control
    output logic                         pulse_enable_o,
    output logic                         hold_min_freq_o,
    output logic                         ramp_down_o,
    output logic                         fast_ramp_o,
    // Source selection
    output logic                         manual_mode_o,
    output logic [2:0]                   cmd_src_o,
    output logic [2:0]                   sp_src_o,
    // Brake
    output logic                         brake_active_status_o,
    output logic                         brake_dout_o
);
    // ****************************************
    // Registers
    // ****************************************
    logic                  brake_sequence_enable_q;
    logic                  dout_brake_func_q;
    logic [1:0]            chg_sel_q;
    logic [7:0]            digital_input3_function_q;
    logic [6:0]            tab_q [2];
    logic [15:0]           brake_release_delay_q;
    logic [15:0]           post_ramp_hold_time_q;
    logic [2:0]            fast_stop_source_a_q;
    logic [2:0]            fast_stop_source_b_q;
    dmbs_pkg::dmbs_state_t state_q;
    dmbs_pkg::dmbs_state_t state_d;
    logic                  status_q;
    logic                  status_d;
    logic                  fast_q;
    logic [15:0]           ms_cnt_q;
    logic [31:0]           pre_q;
    logic                  ms_tick;
    logic                  delay_done;
    logic                  di3_s1_q;
    logic                  di3_s2_q;
    logic                  manual_auto_changeover;
    logic                  act_on;
    logic                  fs_hit;
    logic                  ph_wr_q;
    logic [7:0]            ph_addr_q;
    logic                  take;
    dmbs_pkg::dmbs_src_t   dec_wr;
    dmbs_pkg::dmbs_src_t   dec_act;
    logic [6:0]            act_code;

    // Command source code to input index
    function automatic logic [2:0] src_index(input logic [2:0] tens);
        case (tens)
            3'h0:    src_index = 3'h0;
            3'h1:    src_index = 3'h1;
            3'h4:    src_index = 3'h2;
            3'h5:    src_index = 3'h3;
            3'h6:    src_index = 3'h4;
            default: src_index = 3'h7;
        endcase
    endfunction

    function automatic logic pick(input logic [4:0] v, input logic [2:0] idx);
        pick = (idx <= 3'h4) ? v[idx] : 1'b0;
    endfunction

    // ****************************************
    // AHB-Lite slave, zero wait states
    // ****************************************
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign take        = hsel_i && hready_i && htrans_i[1];

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ph_wr_q   <= 1'b0;
            ph_addr_q <= 8'h00;
        end else begin
            ph_wr_q   <= take && hwrite_i;
            ph_addr_q <= haddr_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (take && !hwrite_i) begin
            case (haddr_i)
                `DMBS_ADDR_CTRL:    hrdata_o <= {16'h0000, digital_input3_function_q, 4'h0,
                                                 chg_sel_q, dout_brake_func_q,
                                                 brake_sequence_enable_q};
                `DMBS_ADDR_SRC_TAB: hrdata_o <= {17'h00000, tab_q[1], 1'b0, tab_q[0]};
                `DMBS_ADDR_REL_DLY: hrdata_o <= {16'h0000, brake_release_delay_q};
                `DMBS_ADDR_HOLD:    hrdata_o <= {16'h0000, post_ramp_hold_time_q};
                `DMBS_ADDR_FSTOP:   hrdata_o <= {21'h00000, fast_stop_source_b_q, 5'h00,
                                                 fast_stop_source_a_q};
                `DMBS_ADDR_STATUS:  hrdata_o <= {16'h0000, 1'b0, sp_src_o, 1'b0, cmd_src_o,
                                                 1'b0, dec_act.valid, fast_q, state_q,
                                                 manual_mode_o, status_q};
                default:            hrdata_o <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            brake_sequence_enable_q   <= 1'(`DMBS_CTRL_RST >> `DMBS_CTRL_BRK_EN);
            dout_brake_func_q         <= 1'(`DMBS_CTRL_RST >> `DMBS_CTRL_DOUT_BRK);
            chg_sel_q                 <= 2'(`DMBS_CTRL_RST >> `DMBS_CTRL_CHG_LSB);
            digital_input3_function_q <= 8'(`DMBS_CTRL_RST >> `DMBS_CTRL_DI3_LSB);
            brake_release_delay_q     <= `DMBS_REL_DLY_RST;
            post_ramp_hold_time_q     <= `DMBS_HOLD_RST;
            fast_stop_source_a_q      <= `DMBS_FS_RST;
            fast_stop_source_b_q      <= `DMBS_FS_RST;
        end else if (ph_wr_q) begin
            case (ph_addr_q)
                `DMBS_ADDR_CTRL: begin
                    brake_sequence_enable_q   <= hwdata_i[`DMBS_CTRL_BRK_EN];
                    dout_brake_func_q         <= hwdata_i[`DMBS_CTRL_DOUT_BRK];
                    chg_sel_q                 <= hwdata_i[`DMBS_CTRL_CHG_LSB +: 2];
                    digital_input3_function_q <= hwdata_i[`DMBS_CTRL_DI3_LSB +: 8];
                end
                `DMBS_ADDR_REL_DLY: brake_release_delay_q <= hwdata_i[15:0];
                `DMBS_ADDR_HOLD:    post_ramp_hold_time_q <= hwdata_i[15:0];
                `DMBS_ADDR_FSTOP: begin
                    fast_stop_source_a_q <= hwdata_i[`DMBS_FS_A_LSB +: 3];
                    fast_stop_source_b_q <= hwdata_i[`DMBS_FS_B_LSB +: 3];
                end
                default: ;
            endcase
        end
    end

    // ****************************************
    // Source table, invalid codes refused
    // ****************************************
    dmbs_src_decode u_dec_wr (
        .code_i (ph_addr_q == `DMBS_ADDR_SRC_TAB && ph_wr_q ? hwdata_i[6:0] : 7'h00),
        .src_o  (dec_wr)
    );

    logic [6:0] wr_e1;
    logic       e1_ok;
    assign wr_e1 = hwdata_i[`DMBS_TAB_E1_LSB +: 7];
    assign e1_ok = (wr_e1 <= 7'h42) && !(wr_e1 inside {7'h0e, 7'h38, 7'h41})
                   && (wr_e1 % 7'h0a <= 7'h06) && !(wr_e1 inside {[7'h14:7'h27]});

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            tab_q[0] <= `DMBS_TAB_RST;
            tab_q[1] <= `DMBS_TAB_RST;
        end else if (ph_wr_q && ph_addr_q == `DMBS_ADDR_SRC_TAB) begin
            if (dec_wr.valid) begin
                tab_q[0] <= hwdata_i[`DMBS_TAB_E0_LSB +: 7];
            end
            if (e1_ok) begin
                tab_q[1] <= wr_e1;
            end
        end
    end

    // ****************************************
    // Manual/automatic changeover
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            di3_s1_q <= 1'b0;
            di3_s2_q <= 1'b0;
        end else begin
            di3_s1_q <= chg_in_i.di3;
            di3_s2_q <= di3_s1_q;
        end
    end

    always_comb begin
        case (chg_sel_q)
            2'h0:    manual_auto_changeover = di3_s2_q &&
                         (digital_input3_function_q == `DMBS_DI3_CHG_FUNC);
            2'h1:    manual_auto_changeover = chg_in_i.panel_cw15;
            2'h2:    manual_auto_changeover = chg_in_i.comm_cw15;
            default: manual_auto_changeover = chg_in_i.board_cw15;
        endcase
    end

    assign act_code = tab_q[manual_auto_changeover];

    dmbs_src_decode u_dec_act (
        .code_i (act_code),
        .src_o  (dec_act)
    );

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            manual_mode_o <= 1'b0;
            cmd_src_o     <= 3'h0;
            sp_src_o      <= 3'h0;
        end else begin
            manual_mode_o <= manual_auto_changeover;
            cmd_src_o     <= dec_act.cmd_src;
            sp_src_o      <= dec_act.sp_src;
        end
    end

    assign act_on = pick(on_req_i, src_index(cmd_src_o));
    assign fs_hit = pick(fast_stop_req_i, fast_stop_source_a_q) ||
                    pick(fast_stop_req_i, fast_stop_source_b_q);

    // ****************************************
    // Millisecond timer, restarted on each state change
    // ****************************************
    assign ms_tick    = (pre_q == 32'(MS_TICK_CYC - 1));
    assign delay_done = (ms_cnt_q == 16'h0000);

    always_ff @(posedge clock_i) begin
        if (srst_i || state_d != state_q) begin
            pre_q <= 32'h0000_0000;
        end else if (ms_tick) begin
            pre_q <= 32'h0000_0000;
        end else begin
            pre_q <= pre_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ms_cnt_q <= 16'h0000;
        end else if (state_d != state_q) begin
            ms_cnt_q <= (state_d == dmbs_pkg::ST_HOLD) ? post_ramp_hold_time_q
                                                       : brake_release_delay_q;
        end else if (ms_tick && !delay_done) begin
            ms_cnt_q <= ms_cnt_q - 16'h0001;
        end
    end

    // ****************************************
    // Brake sequence
    // ****************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            dmbs_pkg::ST_IDLE:    if (act_on && !fs_hit) state_d = dmbs_pkg::ST_PREP;
            dmbs_pkg::ST_PREP:    state_d = brake_sequence_enable_q ? dmbs_pkg::ST_RELEASE
                                                                    : dmbs_pkg::ST_RUN;
            dmbs_pkg::ST_RELEASE: if (!act_on || fs_hit) state_d = dmbs_pkg::ST_RAMP;
                                  else if (delay_done) state_d = dmbs_pkg::ST_RUN;
            dmbs_pkg::ST_RUN:     if (!act_on || fs_hit) state_d = dmbs_pkg::ST_RAMP;
            dmbs_pkg::ST_RAMP:    if (brake_sequence_enable_q) begin
                                      if (at_min_freq_i) state_d = dmbs_pkg::ST_HOLD;
                                  end else if (stop_thr_done_i) begin
                                      state_d = dmbs_pkg::ST_IDLE;
                                  end
            dmbs_pkg::ST_HOLD:    if (delay_done || !brake_sequence_enable_q) begin
                                      state_d = dmbs_pkg::ST_IDLE;
                                  end
            default:              state_d = dmbs_pkg::ST_IDLE;
        endcase
        if (coast_stop_i) begin
            state_d = dmbs_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_q <= dmbs_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i || state_d == dmbs_pkg::ST_IDLE) begin
            fast_q <= 1'b0;
        end else if (fs_hit && state_d == dmbs_pkg::ST_RAMP) begin
            fast_q <= 1'b1;
        end
    end

    // Brake opens only on release entry, stays open until hold, coast or sequence disable
    assign status_d = brake_sequence_enable_q && !coast_stop_i &&
                      (state_d == dmbs_pkg::ST_RELEASE || (status_q &&
                       state_d inside {dmbs_pkg::ST_RUN, dmbs_pkg::ST_RAMP}));

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            status_q <= 1'b0;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pulse_enable_o  <= 1'b0;
            hold_min_freq_o <= 1'b0;
            ramp_down_o     <= 1'b0;
            fast_ramp_o     <= 1'b0;
            brake_dout_o    <= 1'b0;
        end else begin
            pulse_enable_o  <= state_d != dmbs_pkg::ST_IDLE;
            hold_min_freq_o <= state_d inside {dmbs_pkg::ST_PREP, dmbs_pkg::ST_RELEASE,
                                               dmbs_pkg::ST_HOLD};
            ramp_down_o     <= state_d == dmbs_pkg::ST_RAMP;
            fast_ramp_o     <= state_d == dmbs_pkg::ST_RAMP && (fast_q || fs_hit);
            brake_dout_o    <= dout_brake_func_q && brake_sequence_enable_q &&
                               status_d;
        end
    end

    assign brake_active_status_o = status_q;

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_release_entry;
        state_q == dmbs_pkg::ST_PREP ##1 state_q == dmbs_pkg::ST_RELEASE;
    endsequence

    a_coast_status_off: assert property (@(posedge clock_i) disable iff (srst_i)
        coast_stop_i |=> !brake_active_status_o && !brake_dout_o)
        else $error("brake status survived coast stop");
    a_coast_pulses_off: assert property (@(posedge clock_i) disable iff (srst_i)
        coast_stop_i |=> !pulse_enable_o && !ramp_down_o)
        else $error("pulses survived coast stop");
    a_disabled_no_brake: assert property (@(posedge clock_i) disable iff (srst_i)
        !brake_sequence_enable_q |=> !status_q && state_q != dmbs_pkg::ST_HOLD)
        else $error("brake active while control disabled");
    a_pulses_before_rel: assert property (@(posedge clock_i) disable iff (srst_i)
        $rose(status_q) |-> $past(pulse_enable_o) && hold_min_freq_o)
        else $error("brake released without holding current");
    a_release_holds_min: assert property (@(posedge clock_i) disable iff (srst_i)
        s_release_entry |-> hold_min_freq_o && !ramp_down_o)
        else $error("not held at minimum frequency during release");
    a_release_delay_done: assert property (@(posedge clock_i) disable iff (srst_i)
        $past(state_q) == dmbs_pkg::ST_RELEASE && state_q == dmbs_pkg::ST_RUN
        |-> $past(delay_done))
        else $error("accelerated before release delay");
    a_hold_after_ramp: assert property (@(posedge clock_i) disable iff (srst_i)
        $past(state_q) == dmbs_pkg::ST_HOLD && state_q == dmbs_pkg::ST_IDLE
        && !$past(coast_stop_i) && $past(brake_sequence_enable_q) |-> $past(delay_done))
        else $error("hold time cut short");
    a_fast_stop_either: assert property (@(posedge clock_i) disable iff (srst_i)
        state_q == dmbs_pkg::ST_RUN && fs_hit && !coast_stop_i
        |=> state_q == dmbs_pkg::ST_RAMP && fast_ramp_o)
        else $error("fast stop not taken");
    a_dout_needs_both: assert property (@(posedge clock_i) disable iff (srst_i)
        $rose(brake_dout_o) |-> $past(dout_brake_func_q) && $past(brake_sequence_enable_q))
        else $error("digital output drove brake without selection");
    a_mode_entry_used: assert property (@(posedge clock_i) disable iff (srst_i)
        ##1 manual_mode_o == $past(manual_auto_changeover)
        && cmd_src_o == $past(dec_act.cmd_src))
        else $error("active table entry not followed");
endmodule // dmbs_top

// [sim/dmbs_far_model.sv]
// Far-side model: ramp generator feedback and brake relay switched by the master
`timescale 1ns/10ps
module dmbs_far_model (
    // Clock
    input  wire logic clock_i,
    // From the block
    input  wire logic ramp_down_i,
    input  wire logic status_i,
    // To the block
    output logic      at_min_freq_o,
    output logic      stop_thr_done_o,
    output logic      relay_o
);
    logic [2:0] cnt_q = 3'h0;
    always_ff @(posedge clock_i) begin
        cnt_q           <= ramp_down_i ? cnt_q + {2'h0, cnt_q != 3'h7} : 3'h0;
        at_min_freq_o   <= ramp_down_i && cnt_q > 3'h3;
        stop_thr_done_o <= ramp_down_i && cnt_q > 3'h5;
        relay_o         <= status_i;
    end
endmodule // dmbs_far_model

// [sim/dmbs_top_tb_top.sv]
// Self-checking bench of the source select and brake sequencer
`timescale 1ns/10ps
`include "dmbs_regs.svh"
module dmbs_top_tb_top;
    logic                   clock_i = 1'b0;
    logic                   srst_i  = 1'b1;
    logic [7:0]             haddr   = 8'h00;
    logic [1:0]             htrans  = 2'h0;
    logic                   hwrite  = 1'b0;
    logic [31:0]            hwdata  = 32'h0;
    logic [31:0]            hrdata, r;
    logic                   rdy, resp, pulse, hold, ramp, fast, man, stat, dout, amin, thr;
    logic [2:0]             cmd, sp;
    logic [4:0]             on_req  = 5'h00;
    logic [4:0]             fs_req  = 5'h00;
    logic                   coast   = 1'b0;
    dmbs_pkg::dmbs_chg_in_t chg     = 4'h0;
    logic [12:0]            rows [5] = '{{7'h2c, 3'h4, 3'h4}, {7'h37, 3'h5, 3'h5},
        {7'h42, 3'h6, 3'h6}, {7'h0a, 3'h1, 3'h0}, {7'h3e, 3'h6, 3'h2}};
    int                     errors = 0, tests_run = 0, n;
    always #20 clock_i = ~clock_i;
    dmbs_top #(.MS_TICK_CYC(4)) uut (.clock_i(clock_i), .srst_i(srst_i), .hsel_i(1'b1),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(rdy), .hreadyout_o(rdy), .hresp_o(resp),
        .hrdata_o(hrdata), .on_req_i(on_req), .fast_stop_req_i(fs_req),
        .coast_stop_i(coast), .chg_in_i(chg), .at_min_freq_i(amin),
        .stop_thr_done_i(thr), .pulse_enable_o(pulse), .hold_min_freq_o(hold),
        .ramp_down_o(ramp), .fast_ramp_o(fast), .manual_mode_o(man), .cmd_src_o(cmd),
        .sp_src_o(sp), .brake_active_status_o(stat), .brake_dout_o(dout));
    dmbs_far_model far (.clock_i(clock_i), .ramp_down_i(ramp), .status_i(stat),
        .at_min_freq_o(amin), .stop_thr_done_o(thr), .relay_o());
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        tests_run++;
        if (got !== ex) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clock_i);
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        n = 0;
        do @(posedge clock_i); while (rdy !== 1'b1 && ++n < 9);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock_i); while (rdy !== 1'b1 && ++n < 18);
        r = hrdata;
        chk("hready", 1'b1, rdy);
        chk("hresp", 1'b0, resp);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clock_i);
        srst_i <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            bus(`DMBS_ADDR_SRC_TAB, 1'b1, {25'h0, rows[i][12:6]});
            repeat (3) @(negedge clock_i);
            chk("cmd", rows[i][5:3], cmd);
            chk("sp", rows[i][2:0], sp);
        end
        bus(`DMBS_ADDR_SRC_TAB, 1'b1, 32'h290e);
        bus(`DMBS_ADDR_CTRL, 1'b1, 32'h4);
        repeat (3) @(negedge clock_i);
        chk("bad_code", 6'h32, {cmd, sp});
        @(posedge clock_i) chg <= 4'h4;
        repeat (3) @(negedge clock_i);
        chk("manual", 7'h61, {man, cmd, sp});
        bus(`DMBS_ADDR_CTRL, 1'b1, 32'h6300);
        @(posedge clock_i) chg <= 4'h8;
        repeat (5) @(negedge clock_i);
        chk("di3_sel", 1'b1, man);
        bus(`DMBS_ADDR_CTRL, 1'b1, 32'h0);
        repeat (3) @(negedge clock_i);
        chk("di3_func", 1'b0, man);
        $display("test source select done");
        bus(`DMBS_ADDR_REL_DLY, 1'b0, 32'h0);
        chk("dly_rst", `DMBS_REL_DLY_RST, r);
        bus(`DMBS_ADDR_REL_DLY, 1'b1, 32'h1);
        bus(`DMBS_ADDR_HOLD, 1'b1, 32'h1);
        bus(`DMBS_ADDR_FSTOP, 1'b1, 32'h0307);
        for (int k = 0; k < 4; k++) begin
            if (k < 3) bus(`DMBS_ADDR_CTRL, 1'b1, {30'h0, k != 1, 1'b1});
            @(posedge clock_i) on_req <= 5'h10;
            for (n = 0; n < 99 && pulse !== 1'b1; n++) @(negedge clock_i);
            chk("prep", 3'h1, {n == 99, stat, hold});
            @(negedge clock_i);
            chk("release", {2'h3, k != 1}, {stat, hold, dout});
            if (k == 3) bus(`DMBS_ADDR_CTRL, 1'b1, 32'h2);
            for (n = 0; n < 99 && hold !== 1'b0; n++) @(negedge clock_i);
            chk("rel_dly", 1'b1, n > 2 && n < 9);
            if (k == 2) begin
                @(posedge clock_i) coast <= 1'b1;
                repeat (2) @(negedge clock_i);
                chk("coast", 3'h0, {stat, pulse, dout});
                @(posedge clock_i) coast <= 1'b0;
                on_req <= 5'h00;
            end else begin
                @(posedge clock_i) on_req <= (k == 1) ? 5'h10 : 5'h00;
                fs_req <= {1'b0, k == 1, 3'h0};
                repeat (2) @(negedge clock_i);
                chk("ramp", {1'b1, k == 1}, {ramp, fast});
                for (n = 0; n < 99 && ramp !== 1'b0; n++) @(negedge clock_i);
                chk("hold", {2'h0, k != 3}, {n == 99, stat, hold});
                for (n = 0; n < 99 && pulse !== 1'b0; n++) @(negedge clock_i);
                chk("hold_time", 1'b1, k == 3 ? n < 3 : n > 2 && n < 9);
                @(posedge clock_i) fs_req <= 5'h00;
                on_req <= 5'h00;
            end
            repeat (3) @(negedge clock_i);
            $display("test stop kind %0d done", k);
        end
        @(posedge clock_i) on_req <= 5'h10;
        repeat (3) @(posedge clock_i);
        srst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        srst_i <= 1'b0;
        repeat (2) @(negedge clock_i);
        chk("rst_out", 5'h00, {pulse, hold, stat, dout, man});
        bus(`DMBS_ADDR_STATUS, 1'b0, 32'h0);
        chk("status", 32'h0000_0040, r);
        $display("test reset done");
        give_verdict;
    end
endmodule // dmbs_top_tb_top
